// ==== logic/rtcua_top.v ====
// real-time clock counter with start handshake, update-busy flag and clock interrupt
// Operation
// - counter is stopped only when start request and status flag are both 0
// - update-in-progress flag is held high about 62.5 ms per time update
// - a clock interrupt request sets the request flag in the irq control register
// - time registers are not captured together; split reads across an update mismatch
// - status flag follows the start request within two count-source cycles
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
`include "rtcua_map.vh"
module rtcua_top #(
  parameter BUSY_CYC = `RTCUA_BUSY_CYC,
  parameter DIV_W = 24,
  parameter [DIV_W-1:0] SRC_DIV0 = 24'h98_967F,
  parameter [DIV_W-1:0] SRC_DIV1 = 24'h00_0009
) (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire clk_en_in,
  input wire [3:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rdata_out,
  output reg irq_out
);
  ////////////////////////////////////////////////////////////////
  reg count_start_request_r;
  reg count_status_flag_r;
  reg hour_format_select_r;
  reg afternoon_flag_r;
  reg int_sel_r;
  reg update_in_progress_r;
  reg [7:0] clock_control_two_r;
  reg [7:0] clock_source_select_reg_r;
  reg [1:0] irq_status_r;
  reg [1:0] irq_mask_r;
  reg [31:0] busy_cnt_r;
  wire stopped;
  wire tick;
  wire wr_stop;
  wire sec_c, min_c, hr_c;
  wire [7:0] sec_v, min_v, hr_v, wk_v;
  wire [7:0] hr_lo, hr_hi;
  wire noon_wrap;

  // stopped means both request and status read 0
  assign stopped = !count_start_request_r && !count_status_flag_r;
  // time and setup writes only take while stopped
  assign wr_stop = wr_in && stopped;

  function dec_hit;
    input [3:0] a;
    input [3:0] ofs;
    begin
      dec_hit = (a == ofs);
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  rtcua_tick_gen #(.DIV_W(DIV_W)) u_tick (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .en_in(clk_en_in),
    .run_in(count_start_request_r | count_status_flag_r),
    .div_in(clock_source_select_reg_r[0] ? SRC_DIV1 : SRC_DIV0),
    .tick_out(tick)
  );

  // status follows the request at the next count-source tick (max two ticks)
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_status_flag_r <= 1'b0;
    end else if (clk_en_in) begin
      if (tick) begin
        count_status_flag_r <= count_start_request_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  wire adv = tick && count_status_flag_r && count_start_request_r;
  assign hr_lo = hour_format_select_r ? 8'h01 : 8'h00;
  assign hr_hi = hour_format_select_r ? 8'h0C : 8'h17;
  // afternoon toggles when a 12h clock passes from 11 to 12
  assign noon_wrap = adv && min_c && hour_format_select_r && (hr_v == 8'h0B);

  rtcua_wrap_cnt #(.W(8)) u_sec (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .en_in(clk_en_in),
    .inc_in(adv), .lo_in(8'h00), .hi_in(8'h3B),
    .load_in(wr_stop && dec_hit(addr_in, `RTCUA_OFS_SEC)), .load_val_in(wdata_in),
    .val_out(sec_v), .carry_out(sec_c)
  );
  rtcua_wrap_cnt #(.W(8)) u_min (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .en_in(clk_en_in),
    .inc_in(sec_c), .lo_in(8'h00), .hi_in(8'h3B),
    .load_in(wr_stop && dec_hit(addr_in, `RTCUA_OFS_MIN)), .load_val_in(wdata_in),
    .val_out(min_v), .carry_out(min_c)
  );
  rtcua_wrap_cnt #(.W(8)) u_hr (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .en_in(clk_en_in),
    .inc_in(min_c), .lo_in(hr_lo), .hi_in(hr_hi),
    .load_in(wr_stop && dec_hit(addr_in, `RTCUA_OFS_HR)), .load_val_in(wdata_in),
    .val_out(hr_v), .carry_out(hr_c)
  );
  rtcua_wrap_cnt #(.W(8)) u_wk (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .en_in(clk_en_in),
    .inc_in(hour_format_select_r ? (noon_wrap && afternoon_flag_r) : hr_c),
    .lo_in(8'h00), .hi_in(8'h06),
    .load_in(wr_stop && dec_hit(addr_in, `RTCUA_OFS_WK)), .load_val_in(wdata_in),
    .val_out(wk_v), .carry_out()
  );

  ////////////////////////////////////////////////////////////////
  // control one, control two, source select
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_start_request_r <= 1'b0;
      hour_format_select_r <= 1'b0;
      afternoon_flag_r <= 1'b0;
      int_sel_r <= 1'b0;
      clock_control_two_r <= `RTCUA_RST_BYTE;
      clock_source_select_reg_r <= `RTCUA_RST_CSR;
    end else if (clk_en_in) begin
      if (noon_wrap) begin
        afternoon_flag_r <= !afternoon_flag_r;
      end
      if (wr_in && dec_hit(addr_in, `RTCUA_OFS_CR1)) begin
        count_start_request_r <= wdata_in[`RTCUA_CR1_START];
        if (stopped) begin
          hour_format_select_r <= wdata_in[`RTCUA_CR1_FMT];
          afternoon_flag_r <= wdata_in[`RTCUA_CR1_PM];
          int_sel_r <= wdata_in[`RTCUA_CR1_INTSEL];
        end
      end
      if (wr_stop && dec_hit(addr_in, `RTCUA_OFS_CR2)) begin
        clock_control_two_r <= wdata_in;
      end
      if (wr_stop && dec_hit(addr_in, `RTCUA_OFS_CSR)) begin
        clock_source_select_reg_r <= wdata_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // update-in-progress window after each seconds update
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      update_in_progress_r <= 1'b0;
      busy_cnt_r <= 32'h0000_0000;
    end else if (clk_en_in) begin
      if (adv) begin
        update_in_progress_r <= 1'b1;
        busy_cnt_r <= BUSY_CYC - 1;
      end else if (busy_cnt_r != 32'h0000_0000) begin
        busy_cnt_r <= busy_cnt_r - 32'h0000_0001;
      end else begin
        update_in_progress_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // sticky status, set wins over write-one clear
  reg min_c_seen_r;
  wire busy_fall = update_in_progress_r && busy_cnt_r == 32'h0000_0000 && !adv;
  wire req_ev = busy_fall && (int_sel_r ? min_c_seen_r : 1'b1);
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      min_c_seen_r <= 1'b0;
    end else if (clk_en_in) begin
      if (min_c) begin
        min_c_seen_r <= 1'b1;
      end else if (busy_fall) begin
        min_c_seen_r <= 1'b0;
      end
    end
  end

  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_status_r <= 2'h0;
      irq_mask_r <= 2'h0;
      irq_out <= 1'b0;
    end else if (clk_en_in) begin
      irq_status_r[`RTCUA_IRQ_REQ] <= req_ev | (irq_status_r[`RTCUA_IRQ_REQ] &
        !(wr_in && dec_hit(addr_in, `RTCUA_OFS_IRQ) && wdata_in[`RTCUA_IRQ_REQ]));
      irq_status_r[`RTCUA_IRQ_SEC] <= adv | (irq_status_r[`RTCUA_IRQ_SEC] &
        !(wr_in && dec_hit(addr_in, `RTCUA_OFS_IRQ) && wdata_in[`RTCUA_IRQ_SEC]));
      if (wr_in && dec_hit(addr_in, `RTCUA_OFS_MASK)) begin
        irq_mask_r <= wdata_in[1:0];
      end
      irq_out <= |(irq_status_r & irq_mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////
  // live read: registers are not snapshotted together
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 8'h00;
    end else if (clk_en_in) begin
      rdata_out <= 8'h00;
      if (rd_in) begin
        case (addr_in)
          `RTCUA_OFS_SEC: rdata_out <= sec_v;
          `RTCUA_OFS_MIN: rdata_out <= min_v;
          `RTCUA_OFS_HR: rdata_out <= hr_v;
          `RTCUA_OFS_WK: rdata_out <= wk_v;
          `RTCUA_OFS_CR1: rdata_out <= {2'b00, update_in_progress_r, int_sel_r, afternoon_flag_r,
            hour_format_select_r, count_status_flag_r, count_start_request_r};
          `RTCUA_OFS_CR2: rdata_out <= clock_control_two_r;
          `RTCUA_OFS_CSR: rdata_out <= clock_source_select_reg_r;
          `RTCUA_OFS_IRQ: rdata_out <= {6'h00, irq_status_r};
          `RTCUA_OFS_MASK: rdata_out <= {6'h00, irq_mask_r};
          default: rdata_out <= 8'h00;
        endcase
      end
    end
  end
endmodule // rtcua_top

// ==== logic/rtcua_map.vh ====
// register offsets, field positions, reset values and timing counts of the real-time clock
`ifndef RTCUA_MAP_VH
`define RTCUA_MAP_VH
`define RTCUA_OFS_SEC 4'h0
`define RTCUA_OFS_MIN 4'h1
`define RTCUA_OFS_HR 4'h2
`define RTCUA_OFS_WK 4'h3
`define RTCUA_OFS_CR1 4'h4
`define RTCUA_OFS_CR2 4'h5
`define RTCUA_OFS_CSR 4'h6
`define RTCUA_OFS_IRQ 4'h7
`define RTCUA_OFS_MASK 4'h8
`define RTCUA_CR1_START 0
`define RTCUA_CR1_STATUS 1
`define RTCUA_CR1_FMT 2
`define RTCUA_CR1_PM 3
`define RTCUA_CR1_INTSEL 4
`define RTCUA_CR1_BUSY 5
`define RTCUA_IRQ_REQ 0
`define RTCUA_IRQ_SEC 1
`define RTCUA_RST_BYTE 8'h00
`define RTCUA_RST_CSR 8'h00
`define RTCUA_CLK_HZ 10000000
`define RTCUA_BUSY_US 62500
`define RTCUA_BUSY_CYC ((`RTCUA_CLK_HZ / 1000000) * `RTCUA_BUSY_US)
`define RTCUA_SYNC_MAX 2
`endif

// ==== logic/rtcua_tick_gen.v ====
// count-source tick generator: divides the core clock by the selected source divider value plus one
`timescale 1ns/1ps
module rtcua_tick_gen #(
  parameter DIV_W = 24
) (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire en_in,
  input wire run_in,
  input wire [DIV_W-1:0] div_in,
  output reg tick_out
);
  reg [DIV_W-1:0] cnt_r;
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r <= {DIV_W{1'b0}};
      tick_out <= 1'b0;
    end else if (en_in) begin
      if (!run_in) begin
        cnt_r <= {DIV_W{1'b0}};
        tick_out <= 1'b0;
      end else if (cnt_r >= div_in) begin
        cnt_r <= {DIV_W{1'b0}};
        tick_out <= 1'b1;
      end else begin
        cnt_r <= cnt_r + {{(DIV_W-1){1'b0}}, 1'b1};
        tick_out <= 1'b0;
      end
    end
  end
endmodule // rtcua_tick_gen

// ==== logic/rtcua_wrap_cnt.v ====
// one wrapping counter digit with carry out
`timescale 1ns/1ps
module rtcua_wrap_cnt #(
  parameter W = 8
) (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire en_in,
  input wire inc_in,
  input wire [W-1:0] lo_in,
  input wire [W-1:0] hi_in,
  input wire load_in,
  input wire [W-1:0] load_val_in,
  output reg [W-1:0] val_out,
  output wire carry_out
);
  assign carry_out = inc_in && (val_out >= hi_in);
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      val_out <= {W{1'b0}};
    end else if (en_in) begin
      if (load_in) begin
        val_out <= load_val_in;
      end else if (carry_out) begin
        val_out <= lo_in;
      end else if (inc_in) begin
        val_out <= val_out + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // rtcua_wrap_cnt

// ==== testbench/rtcua_assertions.sv ====
// port checker for the real-time clock block
`timescale 1ns/1ps
`include "rtcua_map.vh"
module rtcua_assertions #(
  parameter DIV_W = 24,
  parameter [DIV_W-1:0] SRC_DIV0 = 24'h98_967F,
  parameter [DIV_W-1:0] SRC_DIV1 = 24'h00_0009
) (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire clk_en_in,
  input wire [3:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire [7:0] rdata_out,
  input wire irq_out
);
  localparam int LIM0 = 2 * (SRC_DIV0 + 1) + 8;
  localparam int LIM1 = 2 * (SRC_DIV1 + 1) + 8;
  reg start_r;
  reg csel_r;
  reg [7:0] mask_r;
  reg [31:0] since_r;
  wire lim_ok = since_r > (csel_r ? LIM1 : LIM0);
  ////////////////////////////////////////////////////////////////
  // shadow of what software last wrote
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      start_r <= 1'b0;
      csel_r <= 1'b0;
      mask_r <= 8'h00;
      since_r <= 32'h0000_0000;
    end else if (clk_en_in) begin
      if (wr_in && addr_in == `RTCUA_OFS_CR1) start_r <= wdata_in[`RTCUA_CR1_START];
      if (wr_in && addr_in == `RTCUA_OFS_CSR && !start_r) csel_r <= wdata_in[0];
      if (wr_in && addr_in == `RTCUA_OFS_MASK) mask_r <= wdata_in;
      if (wr_in && addr_in == `RTCUA_OFS_CR1) since_r <= 32'h0000_0000;
      else if (since_r != 32'hFFFF_FFFF) since_r <= since_r + 32'h0000_0001;
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  chk_read_idle:
    assert property (!$past(rd_in) |-> rdata_out == 8'h00) else $error("read data outside read slot");
  chk_unmapped_zero:
    assert property (rd_in && addr_in > 4'h8 |=> rdata_out == 8'h00) else $error("unmapped read not zero");
  chk_start_echo:
    assert property (rd_in && addr_in == `RTCUA_OFS_CR1 |=> rdata_out[0] == $past(start_r))
    else $error("start bit readback wrong");
  chk_status_sync:
    assert property (rd_in && addr_in == `RTCUA_OFS_CR1 && lim_ok |=> rdata_out[1] == $past(start_r))
    else $error("status flag did not follow start");
  chk_irq_masked:
    assert property ($past(mask_r) == 8'h00 |-> !irq_out) else $error("irq while masked");
  chk_irq_read:
    assert property (rd_in && addr_in == `RTCUA_OFS_IRQ ##1 (rdata_out & $past(mask_r)) != 8'h00 |-> irq_out)
    else $error("irq low with unmasked status");
  chk_time_range:
    assert property (rd_in && addr_in < 4'h2 |=> rdata_out < 8'h3C) else $error("seconds or minutes out of range");
  chk_hour_range:
    assert property (rd_in && addr_in == `RTCUA_OFS_HR |=> rdata_out < 8'h18) else $error("hours out of range");
endmodule // rtcua_assertions
bind rtcua_top rtcua_assertions #(.DIV_W(DIV_W), .SRC_DIV0(SRC_DIV0), .SRC_DIV1(SRC_DIV1)) u_chk (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out));

// ==== testbench/tb.sv ====
// self-checking bench of the real-time clock block
`timescale 1ns/1ps
`include "rtcua_map.vh"
module tb;
  localparam int BUSY = 20;
  reg core_clk_in = 1'b0;
  reg rst_n_in = 1'b0;
  reg [3:0] addr_in = 4'h0;
  reg [7:0] wdata_in = 8'h00;
  reg wr_in = 1'b0;
  reg rd_in = 1'b0;
  reg clk_en_in = 1'b1;
  wire [7:0] rdata_out;
  wire irq_out;
  int errors = 0;
  int check_count = 0;
  logic [7:0] d;
  always #50 core_clk_in = ~core_clk_in;
  // selected source ticks every 60 cycles
  rtcua_top #(.BUSY_CYC(BUSY), .SRC_DIV1(24'h00_003B)) i_dut (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out));
  ////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= v;
    @(posedge core_clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge core_clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge core_clk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask
  // polls control one until bit b equals v; n is the poll count
  task automatic wait_bit(input int b, input logic v, output int n);
    n = 0;
    do begin
      rd(`RTCUA_OFS_CR1, d);
      n++;
      if (n > 200) begin
        errors++;
        $display("Error at %0t: wait on control bit %0d timed out", $time, b);
        end_sim();
      end
    end while (d[b] !== v);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    for (int a = 0; a < 10; a++) begin
      rd(a[3:0], d);
      chk(d, 8'h00, "reset value");
    end
    chk({7'h00, irq_out}, 8'h00, "irq after reset");
    $display("test reset done");
  endtask
  task automatic t_run(input logic [7:0] cfg, input logic [7:0] hr0, input logic [7:0] hrx,
                       input logic [7:0] wkx, input logic [7:0] cr1x);
    int n;
    int m;
    logic [7:0] s;
    wr(`RTCUA_OFS_CSR, 8'h01);
    wr(`RTCUA_OFS_CR1, cfg);
    wr(`RTCUA_OFS_SEC, 8'h3B);
    wr(`RTCUA_OFS_MIN, 8'h3B);
    wr(`RTCUA_OFS_HR, hr0);
    wr(`RTCUA_OFS_WK, 8'h02);
    wr(`RTCUA_OFS_CR2, 8'h00);
    wr(`RTCUA_OFS_CR1, cfg | 8'h01);
    wait_bit(`RTCUA_CR1_STATUS, 1'b1, n);
    chk(8'(n <= 62), 8'h01, "status follow time");
    // refused while running: a taken write would end at 16
    wr(`RTCUA_OFS_SEC, 8'h15);
    wait_bit(`RTCUA_CR1_BUSY, 1'b1, n);
    wait_bit(`RTCUA_CR1_BUSY, 1'b0, m);
    chk(8'(m * 2 >= BUSY - 4 && m * 2 <= BUSY + 4), 8'h01, "busy length");
    rd(`RTCUA_OFS_SEC, s);
    chk(s, 8'h00, "seconds");
    rd(`RTCUA_OFS_MIN, d);
    chk(d, 8'h00, "minutes");
    rd(`RTCUA_OFS_HR, d);
    chk(d, hrx, "hours");
    rd(`RTCUA_OFS_WK, d);
    chk(d, wkx, "weekday");
    rd(`RTCUA_OFS_CR1, d);
    chk(d, cr1x, "control one");
    rd(`RTCUA_OFS_SEC, d);
    chk(d, s, "seconds reread");
    wr(`RTCUA_OFS_CR1, 8'h00);
    wait_bit(`RTCUA_CR1_STATUS, 1'b0, n);
    wait_bit(`RTCUA_CR1_BUSY, 1'b0, n);
    $display("test run %h done", cfg);
  endtask
  task automatic t_irq();
    rd(`RTCUA_OFS_IRQ, d);
    chk(d & 8'h01, 8'h01, "request flag");
    chk({7'h00, irq_out}, 8'h00, "masked irq");
    wr(`RTCUA_OFS_MASK, 8'h01);
    repeat (2) @(posedge core_clk_in);
    #1 chk({7'h00, irq_out}, 8'h01, "unmasked irq");
    rd(`RTCUA_OFS_IRQ, d);
    chk(d, 8'h03, "unmasked status");
    wr(`RTCUA_OFS_IRQ, 8'h03);
    repeat (2) @(posedge core_clk_in);
    #1 chk({7'h00, irq_out}, 8'h00, "cleared irq");
    rd(`RTCUA_OFS_IRQ, d);
    chk(d, 8'h00, "status cleared");
    wr(`RTCUA_OFS_MASK, 8'h00);
    $display("test irq done");
  endtask
  task automatic t_freeze();
    @(posedge core_clk_in);
    clk_en_in <= 1'b0;
    wr(`RTCUA_OFS_MASK, 8'h03);
    clk_en_in <= 1'b1;
    rd(`RTCUA_OFS_MASK, d);
    chk(d, 8'h00, "write while frozen");
    $display("test freeze done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_run(8'h00, 8'h17, 8'h00, 8'h03, 8'h03);
    t_irq();
    t_freeze();
    t_run(8'h14, 8'h0B, 8'h0C, 8'h02, 8'h1F);
    t_irq();
    end_sim();
  end
endmodule // tb
